// ==== hdl/phase_shift_bridge_pwm.sv ====
// phase-shifted full-bridge pwm with rectifier drive and trip
//
// Contract
// R1: each of three timers spans 600 count ticks per switching period.
// R2: leg timers count up only; rectifier timer counts up then down.
// R3: each leg drives a complementary pair, 50% duty each.
// R4: leg b phase adjustable while running, counters never stop.
// R5: phase command sets leg shift; more shift, more diagonal overlap.
// R6: controller computes phase offset as Q24 phase times period over 2^25.
// R7: each diagonal pair is on together once per period.
// R8: overlap is largest as shift approaches 180 degrees.
// R9: control interrupt on leg a counter equal to zero.
// R10: controller writes both phase offsets inside each interrupt.
// R11: conversion trigger sits at midpoint of diagonal overlap.
// R12: leg b trigger a starts five conversions once per period.
// R13: controller rescales each 12-bit result to Q24.
// R14: current above 10-bit threshold gives one-shot trip to all timers.
// R15: trip forces all six outputs low at once.
// R16: trip holds outputs low until device reset.
// R17: leg a drives passive-active pair, leg b other pair, rectifier its two.
// R18: rectifier modes: off, on in matching overlap, off in opposite overlap.
// R19: mode and phase changes give no glitches on outputs; mode here switches at the rectifier valley, even mid-pulse.
// R20: each leg has its own programmable dead band.
// R21: new phase offsets take effect at the counter sync event.
`timescale 1ns/1ps
module phase_shift_bridge_pwm import psfb_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// phase and dead band settings
	input wire logic [9:0] leg_b_phase_offset,
	input wire logic [9:0] rectifier_phase_offset,
	input wire logic [7:0] passive_active_dead_band,
	input wire logic [7:0] active_passive_dead_band,
	input wire logic [1:0] rect_mode,
	// overcurrent comparison
	input wire logic [9:0] winding_current,
	input wire logic [9:0] trip_threshold,
	// gate drive outputs
	output logic leg_a_out_hi,
	output logic leg_a_out_lo,
	output logic leg_b_out_hi,
	output logic leg_b_out_lo,
	output logic rect_out_one,
	output logic rect_out_two,
	// events
	output logic counter_zero_event,
	output logic conversion_trigger_a,
	output logic adc_convert_start,
	output logic [2:0] adc_channel,
	output logic trip_active
);
	function automatic logic [9:0] clamp(input logic [9:0] v,
		input logic [9:0] top);
		clamp = (v > top) ? top : v;
	endfunction : clamp

	// {hi, lo}: hi in first half, lo in second, both delayed by dead band
	function automatic logic [1:0] leg_drive(input logic [9:0] cnt,
		input logic [7:0] db);
		logic [9:0] dbw;
		dbw = {2'h0, db};
		leg_drive = {(cnt >= dbw) && (cnt < HALF_TICKS),
			cnt >= HALF_TICKS + dbw};
	endfunction : leg_drive

	logic [9:0] a_count;
	logic [9:0] b_count;
	logic [9:0] r_count;
	logic r_down;
	logic [9:0] phase_q;
	logic trip_q;
	logic over;
	logic force_low;
	logic sync_evt;
	logic [1:0] a_drv;
	logic [1:0] b_drv;
	logic diag_one;
	logic diag_two;
	logic trig_hit;
	rect_mode_t mode_q;
	rect_mode_t mode_in;
	logic [2:0] adc_left_q;
	logic [2:0] adc_gap_q;

	// leg b and rectifier reload when leg a wraps to zero
	assign sync_evt = (a_count == PERIOD_VALUE); // R21

	pwm_time_base #(.UP_DOWN(1'b0)) leg_a_timer ( // R1 R2
		.core_clk(core_clk),
		.reset(reset),
		.sync_load(1'b0),
		.phase_value(COUNT_ZERO),
		.count_q(a_count),
		.down_q()
	);

	pwm_time_base #(.UP_DOWN(1'b0)) leg_b_timer ( // R2 R4
		.core_clk(core_clk),
		.reset(reset),
		.sync_load(sync_evt),
		.phase_value(clamp(leg_b_phase_offset, PERIOD_VALUE)),
		.count_q(b_count),
		.down_q()
	);

	pwm_time_base #(.UP_DOWN(1'b1)) rectifier_timer ( // R2
		.core_clk(core_clk),
		.reset(reset),
		.sync_load(sync_evt),
		.phase_value(clamp(rectifier_phase_offset, HALF_TICKS)),
		.count_q(r_count),
		.down_q(r_down)
	);

	always_ff @(posedge core_clk) begin
		if (reset)
			phase_q <= COUNT_ZERO;
		else if (sync_evt)
			phase_q <= clamp(leg_b_phase_offset, PERIOD_VALUE); // R21
	end

	assign a_drv = leg_drive(a_count, passive_active_dead_band); // R3 R20
	assign b_drv = leg_drive(b_count, active_passive_dead_band); // R3 R20
	// raw overlaps ignore dead band; leg b leads leg a by phase_q ticks
	assign diag_one = (a_count < HALF_TICKS)
		&& (b_count >= HALF_TICKS); // R5 R7 R8
	assign diag_two = (a_count >= HALF_TICKS)
		&& (b_count < HALF_TICKS); // R7

	// overcurrent comparator, latched until reset
	assign over = winding_current > trip_threshold; // R14
	assign force_low = over || trip_q; // R15

	always_ff @(posedge core_clk) begin
		if (reset)
			trip_q <= 1'b0;
		else if (over)
			trip_q <= 1'b1; // R16
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			trip_active <= 1'b0;
		else
			trip_active <= force_low;
	end

	always_comb begin
		unique case (rect_mode)
			MODE_CODE_IDEAL: mode_in = RECT_IDEAL;
			MODE_CODE_FORCED: mode_in = RECT_FORCED;
			default: mode_in = RECT_DIODE;
		endcase
	end

	// mode taken at the rectifier valley; the new mode applies mid-pulse if the valley falls inside one
	always_ff @(posedge core_clk) begin
		if (reset)
			mode_q <= RECT_DIODE;
		else if (r_count == COUNT_ZERO && !r_down)
			mode_q <= mode_in; // R19
	end

	always_ff @(posedge core_clk) begin
		if (reset || force_low) begin // R15 R16
			leg_a_out_hi <= 1'b0;
			leg_a_out_lo <= 1'b0;
			leg_b_out_hi <= 1'b0;
			leg_b_out_lo <= 1'b0;
			rect_out_one <= 1'b0;
			rect_out_two <= 1'b0;
		end else begin
			leg_a_out_hi <= a_drv[1]; // R17
			leg_a_out_lo <= a_drv[0];
			leg_b_out_hi <= b_drv[1]; // R17
			leg_b_out_lo <= b_drv[0];
			unique case (mode_q) // R18
				RECT_IDEAL: begin
					rect_out_one <= diag_one;
					rect_out_two <= diag_two;
				end
				RECT_FORCED: begin
					rect_out_one <= !diag_two;
					rect_out_two <= !diag_one;
				end
				RECT_DIODE: begin
					rect_out_one <= 1'b0;
					rect_out_two <= 1'b0;
				end
			endcase
		end
	end

	// high while leg a counter reads zero after a wrap from 599
	always_ff @(posedge core_clk) begin
		if (reset)
			counter_zero_event <= 1'b0;
		else
			counter_zero_event <= sync_evt; // R9
	end

	// midpoint of diag_one, seen on the leg b count
	assign trig_hit = (phase_q != COUNT_ZERO) &&
		(b_count == HALF_TICKS + {1'b0, phase_q[9:1]}); // R11 R12

	always_ff @(posedge core_clk) begin
		if (reset)
			conversion_trigger_a <= 1'b0;
		else
			conversion_trigger_a <= trig_hit;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			adc_left_q <= 3'h0;
			adc_gap_q <= 3'h0;
			adc_convert_start <= 1'b0;
			adc_channel <= 3'h0;
		end else begin
			adc_convert_start <= 1'b0;
			if (trig_hit) begin
				adc_left_q <= ADC_CONVERSIONS; // R12
				adc_gap_q <= 3'h0;
			end else if (adc_left_q != 3'h0) begin
				if (adc_gap_q == 3'h0) begin
					adc_convert_start <= 1'b1;
					adc_channel <= ADC_CONVERSIONS - adc_left_q;
					adc_left_q <= adc_left_q - 3'h1;
					adc_gap_q <= ADC_GAP - 3'h1;
				end else begin
					adc_gap_q <= adc_gap_q - 3'h1;
				end
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence five_starts;
		adc_convert_start ##4 adc_convert_start ##4 adc_convert_start
			##4 adc_convert_start ##4 adc_convert_start;
	endsequence

	period_wrap_a: assert property ( // R1
		a_count == PERIOD_VALUE |=> a_count == 10'h000)
		else $error("leg a counter did not wrap after 599");
	leg_b_up_a: assert property ( // R2
		!sync_evt && b_count != PERIOD_VALUE
		|=> b_count == $past(b_count) + 10'h001)
		else $error("leg b counter not counting up");
	rect_turn_a: assert property ( // R2
		r_count == HALF_TICKS && !sync_evt |=> r_down)
		else $error("rectifier timer did not turn down at top");
	leg_comp_a: assert property ( // R3
		!(leg_a_out_hi && leg_a_out_lo) && !(leg_b_out_hi && leg_b_out_lo))
		else $error("complementary outputs both high");
	phase_load_a: assert property (sync_evt |=> b_count == phase_q) // R21
		else $error("leg b did not load phase at sync");
	// no event at the zero that directly follows reset, only after a wrap
	zero_irq_a: assert property ( // R9
		counter_zero_event == (a_count == 10'h000
		&& $past(a_count) == PERIOD_VALUE))
		else $error("zero event not aligned to leg a zero");
	trip_now_a: assert property ( // R15
		over |=> !leg_a_out_hi && !leg_a_out_lo && !leg_b_out_hi
		&& !leg_b_out_lo && !rect_out_one && !rect_out_two)
		else $error("outputs not forced low after trip");
	trip_hold_a: assert property ( // R16
		trip_q |=> trip_q && trip_active
		&& !leg_a_out_hi && !leg_b_out_hi && !rect_out_one)
		else $error("trip released without reset");
	adc_burst_a: assert property ( // R12
		conversion_trigger_a && !$past(trig_hit, 2) |=> five_starts)
		else $error("conversion burst not five starts");
	diode_mode_a: assert property ( // R18
		mode_q == RECT_DIODE |=> !rect_out_one && !rect_out_two)
		else $error("rectifier on in diode mode");
endmodule : phase_shift_bridge_pwm

// ==== include/psfb_pkg.sv ====
// constants and types shared by the phase-shifted bridge pwm block
package psfb_pkg;
	localparam int COUNT_W = 10;
	localparam int DB_W = 8;
	localparam int CUR_W = 10;
	// 600 ticks per switching period, counter runs 0..599
	localparam logic [9:0] PERIOD_VALUE = 10'h257;
	localparam logic [9:0] HALF_TICKS = 10'h12C;
	localparam logic [9:0] COUNT_ONE = 10'h001;
	localparam logic [9:0] COUNT_ZERO = 10'h000;
	// analog conversion sequence
	localparam logic [2:0] ADC_CONVERSIONS = 3'h5;
	localparam logic [2:0] ADC_GAP = 3'h4;
	// rect_mode port codes
	localparam logic [1:0] MODE_CODE_IDEAL = 2'h1;
	localparam logic [1:0] MODE_CODE_FORCED = 2'h2;
	typedef enum logic [1:0] {RECT_DIODE, RECT_IDEAL, RECT_FORCED} rect_mode_t;
endpackage : psfb_pkg

// ==== hdl/pwm_time_base.sv ====
// time-base counter, up or up-down, with phase load on sync
`timescale 1ns/1ps
module pwm_time_base import psfb_pkg::*; #(
	parameter bit UP_DOWN = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// synchronisation
	input wire logic sync_load,
	input wire logic [9:0] phase_value,
	// counter state
	output logic [9:0] count_q,
	output logic down_q
);
	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_q <= COUNT_ZERO;
			down_q <= 1'b0;
		end else if (sync_load) begin
			count_q <= phase_value;
			down_q <= 1'b0;
		end else if (!UP_DOWN) begin
			count_q <= (count_q == PERIOD_VALUE) ? COUNT_ZERO
				: count_q + COUNT_ONE;
			down_q <= 1'b0;
		end else if (!down_q) begin
			// top of the triangle is HALF_TICKS, 600 states per period
			if (count_q >= HALF_TICKS) begin
				count_q <= HALF_TICKS - COUNT_ONE;
				down_q <= 1'b1;
			end else begin
				count_q <= count_q + COUNT_ONE;
			end
		end else if (count_q <= COUNT_ONE) begin
			count_q <= COUNT_ZERO;
			down_q <= 1'b0;
		end else begin
			count_q <= count_q - COUNT_ONE;
		end
	end
endmodule : pwm_time_base

// ==== verification/gate_driver_model.sv ====
// gate driver stage model: flags a leg with both switches on
`timescale 1ns/1ps
module gate_driver_model (
	// gate commands from the bridge pwm
	input wire logic leg_a_out_hi,
	input wire logic leg_a_out_lo,
	input wire logic leg_b_out_hi,
	input wire logic leg_b_out_lo,
	// observation
	output logic leg_short
);
	// both switches of one leg on shorts the bus through that leg
	assign leg_short = (leg_a_out_hi & leg_a_out_lo) |
		(leg_b_out_hi & leg_b_out_lo);
endmodule : gate_driver_model

// ==== verification/testbench.sv ====
// self-checking bench for the phase-shifted bridge pwm
`timescale 1ns/1ps
module testbench import psfb_pkg::*;;
	logic core_clk, reset, leg_short;
	logic [9:0] leg_b_phase_offset, rectifier_phase_offset;
	logic [7:0] passive_active_dead_band, active_passive_dead_band;
	logic [1:0] rect_mode;
	logic [9:0] winding_current, trip_threshold;
	logic leg_a_out_hi, leg_a_out_lo, leg_b_out_hi, leg_b_out_lo;
	logic rect_out_one, rect_out_two, counter_zero_event, trip_active;
	logic conversion_trigger_a, adc_convert_start;
	logic [2:0] adc_channel, chan_q;
	logic [31:0] lfsr_q;
	logic [23:0] corner_q [4] = '{24'h000000, 24'h200000, 24'h800000,
		24'hFFFE00};
	int miscompares, n_tests, cycles;

	phase_shift_bridge_pwm phase_shift_bridge_pwm_i (.core_clk(core_clk),
		.reset(reset), .leg_b_phase_offset(leg_b_phase_offset),
		.rectifier_phase_offset(rectifier_phase_offset),
		.passive_active_dead_band(passive_active_dead_band),
		.active_passive_dead_band(active_passive_dead_band),
		.rect_mode(rect_mode), .winding_current(winding_current),
		.trip_threshold(trip_threshold), .leg_a_out_hi(leg_a_out_hi),
		.leg_a_out_lo(leg_a_out_lo), .leg_b_out_hi(leg_b_out_hi),
		.leg_b_out_lo(leg_b_out_lo), .rect_out_one(rect_out_one),
		.rect_out_two(rect_out_two),
		.counter_zero_event(counter_zero_event),
		.conversion_trigger_a(conversion_trigger_a),
		.adc_convert_start(adc_convert_start), .adc_channel(adc_channel),
		.trip_active(trip_active));
	gate_driver_model gate_driver_model_i (.leg_a_out_hi(leg_a_out_hi),
		.leg_a_out_lo(leg_a_out_lo), .leg_b_out_hi(leg_b_out_hi),
		.leg_b_out_lo(leg_b_out_lo), .leg_short(leg_short));

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand

	// controller side: q24 command times period value over 2^25
	function automatic logic [9:0] phase_ticks(input logic [23:0] q);
		logic [63:0] p;
		p = {40'h0, q} * 64'h257;
		return p[34:25];
	endfunction : phase_ticks

	// controller side: 12-bit result as a q24 fraction of full scale
	function automatic logic [31:0] result_q24(input logic [11:0] r);
		return {8'h00, r, 12'h000};
	endfunction : result_q24

	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic summarize();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick

	task automatic wait_zero(output int n);
		n = 0;
		do begin
			tick();
			n++;
		end while (counter_zero_event !== 1'b1 && n < 700);
	endtask : wait_zero

	// one full period from a zero event, inputs held steady meanwhile
	task automatic run_period(input int ph, dba, dbb, input logic [1:0] md);
		int ha, la, hb, lb, r1, r2, tr, tp, st, ze, sh, e1, xs;
		{ha, la, hb, lb, r1, r2, tr, tp, st, ze, sh, xs} = '0;
		e1 = md == 2'h1 ? ph : md == 2'h2 ? 600 - ph : 0;
		for (int i = 0; i < 600; i++) begin
			ha += leg_a_out_hi;
			la += leg_a_out_lo;
			hb += leg_b_out_hi;
			lb += leg_b_out_lo;
			r1 += rect_out_one;
			r2 += rect_out_two;
			ze += counter_zero_event;
			sh += leg_short;
			// int sums would hide unknowns, so count them apart
			xs += $isunknown({leg_a_out_hi, leg_a_out_lo, leg_b_out_hi,
				leg_b_out_lo, rect_out_one, rect_out_two, leg_short,
				counter_zero_event, conversion_trigger_a,
				adc_convert_start});
			if (conversion_trigger_a === 1'b1) begin
				tr++;
				tp = i;
			end
			if (adc_convert_start === 1'b1) begin
				check(adc_channel === chan_q, "adc channel order");
				chan_q = chan_q == 3'h4 ? 3'h0 : chan_q + 3'h1;
				st++;
			end
			tick();
		end
		check(ze == 1 && counter_zero_event === 1'b1, "period");
		check(ha == 300 - dba && la == 300 - dba, "leg a duty");
		check(hb == 300 - dbb && lb == 300 - dbb, "leg b duty");
		check(sh == 0, "leg shoot-through");
		check(xs == 0, "unknown on outputs");
		check(r1 == e1 && r2 == e1, "rectifier overlap");
		check(tr == (ph != 0), "trigger count");
		// conversion_trigger_a is registered, so the overlap midpoint lands one
		// tick later than on the raw leg b count
		check(ph == 0 || tp == 301 - (ph - ph / 2), "trigger spot");
		check(st == 5 * tr, "conversion count");
	endtask : run_period

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// a hang counts as a failure
	always @(posedge core_clk) begin
		cycles++;
		if (cycles >= 40000) begin
			miscompares++;
			summarize();
		end
	end

	initial begin
		logic [23:0] q;
		int n, ph, dba, dbb;
		{miscompares, n_tests, cycles} = '0;
		lfsr_q = 32'h000181BB;
		chan_q = 3'h0;
		reset = 1'b1;
		{leg_b_phase_offset, rectifier_phase_offset} = '0;
		{passive_active_dead_band, active_passive_dead_band} = '0;
		rect_mode = 2'h0;
		winding_current = 10'h000;
		trip_threshold = 10'h3FF;
		repeat (2) tick();
		check({leg_a_out_hi, leg_a_out_lo, leg_b_out_hi, leg_b_out_lo,
			rect_out_one, rect_out_two} === 6'h00, "reset outputs");
		reset = 1'b0;
		wait_zero(n);
		check(n >= 599 && n <= 601, "first zero event");
		check(result_q24(12'h800) === 32'h00800000, "q24 half scale");
		check(result_q24(12'h000) === 32'h00000000, "q24 zero");
		for (int k = 0; k < 12; k++) begin
			lfsr_q = next_rand(lfsr_q);
			q = k < 4 ? corner_q[k] : lfsr_q[23:0];
			ph = phase_ticks(q);
			dba = k == 1 ? 0 : lfsr_q[28:24];
			dbb = k == 2 ? 0 : lfsr_q[20:16];
			// written just after the zero event, as the interrupt does
			leg_b_phase_offset = ph[9:0];
			rectifier_phase_offset = {1'b0, lfsr_q[8:0]};
			passive_active_dead_band = dba[7:0];
			active_passive_dead_band = dbb[7:0];
			rect_mode = k < 4 ? k[1:0] : lfsr_q[31:30];
			winding_current = k == 0 ? 10'h3FF : lfsr_q[9:0];
			wait_zero(n);
			wait_zero(n);
			run_period(ph, dba, dbb, rect_mode);
		end
		repeat (123) tick();
		trip_threshold = 10'h1FF;
		winding_current = 10'h200;
		repeat (2) tick();
		check({leg_a_out_hi, leg_a_out_lo, leg_b_out_hi, leg_b_out_lo,
			rect_out_one, rect_out_two, trip_active} === 7'h01,
			"trip");
		winding_current = 10'h000;
		n = 0;
		repeat (700) begin
			tick();
			n += leg_a_out_hi | leg_b_out_hi | rect_out_one | !trip_active;
		end
		check(n == 0, "trip released early");
		reset = 1'b1;
		repeat (2) tick();
		reset = 1'b0;
		n = 0;
		repeat (700) begin
			tick();
			n += leg_a_out_hi;
		end
		check(n > 0 && trip_active === 1'b0, "reset clears trip");
		summarize();
	end
endmodule : testbench
